// *** rx_payload_control.sv ***
// Receive payload conditioning block
`timescale 1ns/100ps
`default_nettype none

module rx_payload_control #(
    parameter int NCH = 32
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [7:0] IN_DATA,
    input wire logic [3:0] IN_SIG,
    input wire logic [4:0] IN_CHAN,
    input wire logic IN_SIG_FRAME,
    input wire logic [7:0] PRBS_GEN_DATA,
    output logic PRBS_DET_VALID,
    output logic [7:0] PRBS_DET_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [7:0] RX_SERIAL_DATA_OUT,
    output logic [3:0] RX_SIGNALING_OUT,
    output logic [4:0] OUT_CHAN
);
    localparam int SW = 17;

    initial begin
        if (NCH < 1 || NCH > 32) begin
            $error("NCH out of range");
        end
    end

    //------------------------------------------------------------
    // Bus slave state
    //------------------------------------------------------------
    logic aw_hold_q, w_hold_q, awready_q, wready_q;
    logic bvalid_q, arready_q, rvalid_q;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [rx_payload_pkg::CTRL_W-1:0] ctrl_q;
    logic [rx_payload_pkg::TEST_W-1:0] test_q;
    logic [rx_payload_pkg::CFG_W-1:0] cfg_q;
    logic [7:0] acc_ctrl_q;
    logic [7:0] acc_data_q;
    logic busy_q;

    // Write channels taken apart, committed together
    wire aw_take = AWVALID & awready_q;
    wire w_take = WVALID & wready_q;
    wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    wire aw_hold_d = (aw_hold_q | aw_take) & ~wr_fire;
    wire w_hold_d = (w_hold_q | w_take) & ~wr_fire;
    wire bvalid_d = wr_fire | (bvalid_q & ~BREADY);
    wire ar_take = ARVALID & arready_q;
    wire rvalid_d = ar_take | (rvalid_q & ~RREADY);

    // Write address decode
    wire wa_ctrl = aw_addr_q == rx_payload_pkg::OFF_CTRL;
    wire wa_test = aw_addr_q == rx_payload_pkg::OFF_TEST;
    wire wa_cfg = aw_addr_q == rx_payload_pkg::OFF_CFG;
    wire wa_acc = aw_addr_q == rx_payload_pkg::OFF_ACC_CTRL;
    wire wa_data = aw_addr_q == rx_payload_pkg::OFF_ACC_DATA;
    wire wa_stat = aw_addr_q == rx_payload_pkg::OFF_ACC_STAT;
    wire wa_hit = wa_ctrl | wa_test | wa_cfg | wa_acc | wa_data | wa_stat;
    wire wr_en = wr_fire & w_lane_q;
    // Access control and data writes while busy are dropped so an access stays whole
    wire acc_go = wr_en & wa_acc & ~busy_q;
    wire data_wr = wr_en & wa_data & ~busy_q;

    // Read decode; unmapped reads give zero and an error
    wire ra_ctrl = ARADDR == rx_payload_pkg::OFF_CTRL;
    wire ra_test = ARADDR == rx_payload_pkg::OFF_TEST;
    wire ra_cfg = ARADDR == rx_payload_pkg::OFF_CFG;
    wire ra_acc = ARADDR == rx_payload_pkg::OFF_ACC_CTRL;
    wire ra_data = ARADDR == rx_payload_pkg::OFF_ACC_DATA;
    wire ra_stat = ARADDR == rx_payload_pkg::OFF_ACC_STAT;
    wire ra_hit = ra_ctrl | ra_test | ra_cfg | ra_acc | ra_data | ra_stat;
    wire [7:0] rd_byte =
        ({8{ra_ctrl}} & {3'h0, ctrl_q}) |
        ({8{ra_test}} & {4'h0, test_q}) |
        ({8{ra_cfg}} & {4'h0, cfg_q}) |
        ({8{ra_acc}} & acc_ctrl_q) |
        ({8{ra_data}} & acc_data_q) |
        ({8{ra_stat}} & {7'h0, busy_q});

    //------------------------------------------------------------
    // Bus handshakes
    //------------------------------------------------------------
    // One write and one read in flight
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awready_q <= ~aw_hold_d;
            wready_q <= ~w_hold_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            arready_q <= ~rvalid_d;
        end
    end

    // Captured payloads and responses
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            bresp_q <= rx_payload_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            rresp_q <= rx_payload_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= AWADDR;
            end
            if (w_take) begin
                w_data_q <= WDATA[7:0];
                w_lane_q <= WSTRB[0];
            end
            if (wr_fire) begin
                bresp_q <= wa_hit ? rx_payload_pkg::RESP_OKAY :
                    rx_payload_pkg::RESP_DECERR;
            end
            if (ar_take) begin
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= ra_hit ? rx_payload_pkg::RESP_OKAY :
                    rx_payload_pkg::RESP_DECERR;
            end
        end
    end

    //------------------------------------------------------------
    // Direct registers and indirect access
    //------------------------------------------------------------
    wire [7:0] tbl_rdata;
    wire tbl_we = busy_q & ~acc_ctrl_q[rx_payload_pkg::ACC_RW];

    // Busy lasts one cycle; a read result beats a data write
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= '0;
            test_q <= '0;
            cfg_q <= '0;
            acc_ctrl_q <= rx_payload_pkg::RST_BYTE;
            acc_data_q <= rx_payload_pkg::RST_BYTE;
            busy_q <= 1'b0;
        end else begin
            if (wr_en & wa_ctrl) begin
                ctrl_q <= w_data_q[rx_payload_pkg::CTRL_W-1:0];
            end
            if (wr_en & wa_test) begin
                test_q <= w_data_q[rx_payload_pkg::TEST_W-1:0];
            end
            if (wr_en & wa_cfg) begin
                cfg_q <= w_data_q[rx_payload_pkg::CFG_W-1:0];
            end
            if (acc_go) begin
                acc_ctrl_q <= w_data_q;
            end
            busy_q <= acc_go;
            if (busy_q & acc_ctrl_q[rx_payload_pkg::ACC_RW]) begin
                acc_data_q <= tbl_rdata;
            end else if (data_wr) begin
                acc_data_q <= w_data_q;
            end
        end
    end

    wire [7:0] ch_ctl, ch_dtrk, ch_strk;

    chan_cfg_table #(.NCH(NCH)) u_table (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .sw_we(tbl_we),
        .sw_addr(acc_ctrl_q[6:0]),
        .sw_wdata(acc_data_q),
        .sw_rdata(tbl_rdata),
        .lk_chan(IN_CHAN),
        .lk_ctl(ch_ctl),
        .lk_dtrk(ch_dtrk),
        .lk_strk(ch_strk)
    );

    //------------------------------------------------------------
    // Payload conditioning chain
    //------------------------------------------------------------
    logic [2:0] mw_phase [NCH];
    wire [2:0] phase = (6'(IN_CHAN) < 6'(NCH)) ? mw_phase[IN_CHAN] : 3'h0;

    // Control decode
    wire en = ctrl_q[rx_payload_pkg::CTRL_EN];
    wire e1 = ctrl_q[rx_payload_pkg::CTRL_E1];
    wire [1:0] pmode = test_q[rx_payload_pkg::TEST_MODE_LO +: 2];
    wire unframed = pmode == rx_payload_pkg::PM_UNFRAMED;
    wire framed = (pmode == rx_payload_pkg::PM_8BIT) |
        (pmode == rx_payload_pkg::PM_7BIT);
    wire ch_test = ch_ctl[rx_payload_pkg::CH_TEST];
    wire prbs_sel = en & test_q[rx_payload_pkg::TEST_EN] &
        (unframed | (framed & ch_test));
    wire prbs_dir = test_q[rx_payload_pkg::TEST_DIR];
    wire tap = prbs_sel & ~prbs_dir;
    wire replace = prbs_sel & prbs_dir;

    // Substitution select: global wins when nonzero
    wire [2:0] gsub = cfg_q[2:0];
    wire [2:0] sub_sel = (gsub != rx_payload_pkg::SUB_NONE) ? gsub :
        ch_ctl[2:0];
    wire use_alaw = (sub_sel == rx_payload_pkg::SUB_MW_ALAW) |
        ((sub_sel == rx_payload_pkg::SUB_MW_AUTO) & e1);
    wire use_ulaw = (sub_sel == rx_payload_pkg::SUB_MW_ULAW) |
        ((sub_sel == rx_payload_pkg::SUB_MW_AUTO) & ~e1);
    wire use_mw = en & (use_alaw | use_ulaw);
    wire use_trk = en & (sub_sel == rx_payload_pkg::SUB_TRUNK);
    wire [7:0] d_sub = use_trk ? ch_dtrk :
        use_mw ? (use_alaw ? rx_payload_pkg::MW_ALAW[phase] :
        rx_payload_pkg::MW_ULAW[phase]) : IN_DATA;

    // Robbed-bit force only in T1 robbed formats
    wire fix_on = en & ctrl_q[rx_payload_pkg::CTRL_SIGNALING_FORCE_ENABLE] & ~e1 &
        ctrl_q[rx_payload_pkg::CTRL_ROBBED];
    wire signaling_force_value = ctrl_q[rx_payload_pkg::CTRL_POL];
    wire [7:0] d_fix = (fix_on & IN_SIG_FRAME) ?
        {d_sub[7:1], signaling_force_value} : d_sub;

    // Inversion masks per channel
    wire [7:0] inv_mask =
        ({8{ch_ctl[rx_payload_pkg::CH_MSB_INV]}} & rx_payload_pkg::MASK_MSB) |
        ({8{ch_ctl[rx_payload_pkg::CH_EVEN_INV]}} & rx_payload_pkg::MASK_EVEN) |
        ({8{ch_ctl[rx_payload_pkg::CH_ODD_INV]}} & rx_payload_pkg::MASK_ODD);
    wire [7:0] d_inv = d_fix ^ ({8{en}} & inv_mask);

    // Pattern insertion; 7-bit mode spares the robbed bit
    wire keep_lsb = pmode == rx_payload_pkg::PM_7BIT;
    wire [7:0] d_out = ~replace ? d_inv : keep_lsb ?
        {PRBS_GEN_DATA[7:1], d_inv[0]} : PRBS_GEN_DATA;

    // Signaling: trunk code, then force value
    wire strk_on = en & (cfg_q[rx_payload_pkg::CFG_GSTRK] |
        ch_strk[rx_payload_pkg::STRK_EN]);
    wire [3:0] s_trk = strk_on ? ch_strk[3:0] : IN_SIG;
    wire [3:0] s_out = fix_on ? {4{signaling_force_value}} : s_trk;

    //------------------------------------------------------------
    // Stream handshake and buffer
    //------------------------------------------------------------
    byte_stream_if #(.W(SW)) buf_in ();
    byte_stream_if #(.W(SW)) buf_out ();

    assign buf_in.valid = IN_VALID;
    assign buf_in.data = {IN_CHAN, s_out, d_out};
    assign buf_out.ready = OUT_READY;
    wire hs = IN_VALID & buf_in.ready;

    two_entry_buffer #(.W(SW)) u_buf (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .in_s(buf_in),
        .out_s(buf_out)
    );

    // Milliwatt phase per channel, wraps after byte eight
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_phase
            always_ff @(posedge CLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    mw_phase[gi] <= rx_payload_pkg::RST_PHASE;
                end else if (hs & use_mw & (IN_CHAN == 5'(gi))) begin
                    mw_phase[gi] <= mw_phase[gi] + 3'h1;
                end
            end
        end
    endgenerate

    // Tap sees the raw byte, one pulse per taken byte
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRBS_DET_VALID <= 1'b0;
            PRBS_DET_DATA <= rx_payload_pkg::RST_BYTE;
        end else begin
            PRBS_DET_VALID <= hs & tap;
            if (hs & tap) begin
                PRBS_DET_DATA <= IN_DATA;
            end
        end
    end

    //------------------------------------------------------------
    // Output wiring from flops
    //------------------------------------------------------------
    assign AWREADY = awready_q;
    assign WREADY = wready_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign IN_READY = buf_in.ready;
    assign OUT_VALID = buf_out.valid;
    assign RX_SERIAL_DATA_OUT = buf_out.data[7:0];
    assign RX_SIGNALING_OUT = buf_out.data[11:8];
    assign OUT_CHAN = buf_out.data[16:12];
endmodule

// Per-channel indirect configuration tables
module chan_cfg_table #(
    parameter int NCH = 32
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic sw_we,
    input wire logic [6:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    output logic [7:0] sw_rdata,
    input wire logic [4:0] lk_chan,
    output logic [7:0] lk_ctl,
    output logic [7:0] lk_dtrk,
    output logic [7:0] lk_strk
);
    logic [7:0] ctl_mem [NCH];
    logic [7:0] dtrk_mem [NCH];
    logic [7:0] strk_mem [NCH];

    // Region and channel decode; out-of-range reads as zero
    wire [1:0] region = sw_addr[6:5];
    wire [4:0] sw_ch = sw_addr[4:0];
    wire sw_ok = 6'(sw_ch) < 6'(NCH);
    wire lk_ok = 6'(lk_chan) < 6'(NCH);
    assign sw_rdata = ~sw_ok ? 8'h00 :
        (region == rx_payload_pkg::REG_CHCTL) ? ctl_mem[sw_ch] :
        (region == rx_payload_pkg::REG_DTRK) ? dtrk_mem[sw_ch] :
        (region == rx_payload_pkg::REG_STRK) ? strk_mem[sw_ch] : 8'h00;
    assign lk_ctl = lk_ok ? ctl_mem[lk_chan] : 8'h00;
    assign lk_dtrk = lk_ok ? dtrk_mem[lk_chan] : 8'h00;
    assign lk_strk = lk_ok ? strk_mem[lk_chan] : 8'h00;

    // One entry per channel, all cleared at reset
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ent
            wire hit = sw_we & (sw_ch == 5'(gi));
            always_ff @(posedge CLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    ctl_mem[gi] <= rx_payload_pkg::RST_BYTE;
                    dtrk_mem[gi] <= rx_payload_pkg::RST_BYTE;
                    strk_mem[gi] <= rx_payload_pkg::RST_BYTE;
                end else if (hit) begin
                    if (region == rx_payload_pkg::REG_CHCTL) begin
                        ctl_mem[gi] <= sw_wdata;
                    end
                    if (region == rx_payload_pkg::REG_DTRK) begin
                        dtrk_mem[gi] <= sw_wdata;
                    end
                    if (region == rx_payload_pkg::REG_STRK) begin
                        strk_mem[gi] <= sw_wdata;
                    end
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// *** rx_payload_pkg.sv ***
// Constants of the receive payload block
//------------------------------------------------------------
// Summary of operation
// - Enable bit gates every conditioning function
// - Methods per channel or global, fixed priority
// - Test extract direction taps data to detector
// - Unframed extract taps whole stream
// - Framed extract taps only test-selected channels
// - Nonzero global select substitutes every channel
// - Zero global select uses per-channel select
// - Signaling force sets ABCD, T1 robbed formats
// - Invert MSB, even and odd bits separately
// - Test replace direction inserts generator pattern
// - Unframed replace overwrites whole stream
// - Framed replace overwrites test-selected channels
// - A-law milliwatt eight byte table
// - Mu-law milliwatt eight byte table
// - Signaling output has its own priority chain
// - Signaling trunk code, global or per channel
// - Indirect access via address, select, data, busy
//------------------------------------------------------------
`default_nettype none

package rx_payload_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TEST = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_ACC_CTRL = 8'h0c;
    localparam logic [7:0] OFF_ACC_DATA = 8'h10;
    localparam logic [7:0] OFF_ACC_STAT = 8'h14;
    // Control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_SIGNALING_FORCE_ENABLE = 1;
    localparam int CTRL_POL = 2;
    localparam int CTRL_E1 = 3;
    localparam int CTRL_ROBBED = 4;
    localparam int CTRL_W = 5;
    // Test register fields
    localparam int TEST_EN = 0;
    localparam int TEST_DIR = 1;
    localparam int TEST_MODE_LO = 2;
    localparam int TEST_W = 4;
    // Configuration register fields
    localparam int CFG_GSTRK = 3;
    localparam int CFG_W = 4;
    // Access control fields
    localparam int ACC_RW = 7;
    // Per-channel control byte and signaling trunk byte fields
    localparam int CH_TEST = 3;
    localparam int CH_MSB_INV = 4;
    localparam int CH_ODD_INV = 5;
    localparam int CH_EVEN_INV = 6;
    localparam int STRK_EN = 4;
    // Indirect regions in address bits 6:5
    localparam logic [1:0] REG_CHCTL = 2'h0;
    localparam logic [1:0] REG_DTRK = 2'h1;
    localparam logic [1:0] REG_STRK = 2'h2;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_PHASE = 3'h0;
    // Framing modes of the test path
    localparam logic [1:0] PM_UNFRAMED = 2'h0;
    localparam logic [1:0] PM_8BIT = 2'h1;
    localparam logic [1:0] PM_7BIT = 2'h2;
    // Substitution codes
    localparam logic [2:0] SUB_NONE = 3'h0;
    localparam logic [2:0] SUB_TRUNK = 3'h1;
    localparam logic [2:0] SUB_MW_AUTO = 3'h2;
    localparam logic [2:0] SUB_MW_ALAW = 3'h3;
    localparam logic [2:0] SUB_MW_ULAW = 3'h4;
    // Inversion masks, line bit 0 is data bit 7
    localparam logic [7:0] MASK_MSB = 8'h80;
    localparam logic [7:0] MASK_EVEN = 8'haa;
    localparam logic [7:0] MASK_ODD = 8'h55;
    // Milliwatt tables, bit 0 of the pattern in data bit 7
    localparam logic [7:0] MW_ALAW [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
        8'hb4, 8'ha1, 8'ha1, 8'hb4};
    localparam logic [7:0] MW_ULAW [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
        8'h9e, 8'h8b, 8'h8b, 8'h9e};
    // Bus responses and buffer depth
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int BUF_DEPTH = 2;
endpackage

`default_nettype wire

// *** byte_stream_if.sv ***
// Valid/ready stream bundle
`timescale 1ns/100ps
`default_nettype none

interface byte_stream_if #(parameter int W = 17);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// *** two_entry_buffer.sv ***
// Two-entry skid buffer with registered ready and outputs
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
    parameter int W = 17
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    byte_stream_if.snk in_s,
    byte_stream_if.src out_s
);
    initial begin
        if (W < 1 || rx_payload_pkg::BUF_DEPTH != 2) begin
            $error("unsupported width or depth");
        end
    end

    logic out_v_q, skid_v_q, rdy_q;
    logic [W-1:0] out_d_q, skid_d_q;
    wire push = in_s.valid & rdy_q;
    wire pop = out_v_q & out_s.ready;
    wire load = ~out_v_q | pop;
    wire skid_v_d = load ? 1'b0 : (skid_v_q | push);

    //------------------------------------------------------------
    // Storage
    //------------------------------------------------------------
    // Ready is a flop: no combinational path upstream
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_v_q <= 1'b0;
            skid_v_q <= 1'b0;
            rdy_q <= 1'b0;
            out_d_q <= '0;
            skid_d_q <= '0;
        end else begin
            skid_v_q <= skid_v_d;
            rdy_q <= ~skid_v_d;
            if (load) begin
                out_v_q <= skid_v_q | push;
                out_d_q <= skid_v_q ? skid_d_q : in_s.data;
            end else if (push) begin
                skid_d_q <= in_s.data;
            end
        end
    end

    assign in_s.ready = rdy_q;
    assign out_s.valid = out_v_q;
    assign out_s.data = out_d_q;
endmodule

`default_nettype wire

// *** rx_payload_checks_assertions.sv ***
// Port-level checks of the payload block
`timescale 1ns/100ps
`default_nettype none
module rx_payload_checks (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic IN_VALID,
    input wire logic IN_READY,
    input wire logic [7:0] IN_DATA,
    input wire logic PRBS_DET_VALID,
    input wire logic [7:0] PRBS_DET_DATA,
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic [7:0] RX_SERIAL_DATA_OUT
);
    // Single clock domain
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wr_latency_a: assert property (AWVALID && AWREADY && WVALID && WREADY
        |-> ##2 BVALID) else $error("write answer late");
    rd_latency_a: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write answer dropped");
    rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID &&
        $stable(RDATA)) else $error("read answer changed");
    out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID &&
        $stable(RX_SERIAL_DATA_OUT)) else $error("output word lost");
    out_latency_a: assert property (IN_VALID && IN_READY && !OUT_VALID
        |=> OUT_VALID) else $error("output word late");
    // Refusal only while full; skip release edge
    full_valid_a: assert property (!IN_READY && !$past(SYS_RST)
        |-> OUT_VALID) else $error("input refused while empty");
    det_source_a: assert property (PRBS_DET_VALID |->
        $past(IN_VALID && IN_READY)) else $error("tap without byte");
    det_data_a: assert property (PRBS_DET_VALID |->
        PRBS_DET_DATA == $past(IN_DATA)) else $error("tap data bad");
    cover property (!IN_READY);
    cover property (PRBS_DET_VALID);
    cover property (RVALID && RREADY);
endmodule
`default_nettype wire

// *** backplane_sink.sv ***
// Backplane side model that stalls the output stream
`timescale 1ns/100ps
`default_nettype none
module backplane_sink (
    input wire logic CLK,
    input wire logic SYS_RST,
    output logic OUT_READY
);
    logic [7:0] lf_q;
    // Free LFSR, so stalls come in runs that fill the buffer
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lf_q <= 8'h5b;
        end else begin
            lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
        end
    end
    assign OUT_READY = lf_q[0] | lf_q[2];
endmodule
`default_nettype wire

// *** rx_payload_control_test.sv ***
// Self-checking bench for the receive payload block
`timescale 1ns/100ps
`default_nettype none
module rx_payload_control_test;
    logic CLK, SYS_RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, IN_VALID, IN_READY;
    logic IN_SIG_FRAME, PRBS_DET_VALID, OUT_VALID, OUT_READY;
    logic [7:0] AWADDR, ARADDR, IN_DATA, PRBS_GEN_DATA, PRBS_DET_DATA;
    logic [7:0] RX_SERIAL_DATA_OUT, d;
    logic [31:0] WDATA, RDATA, s;
    logic [3:0] WSTRB, IN_SIG, RX_SIGNALING_OUT;
    logic [1:0] BRESP, RRESP, r;
    logic [4:0] IN_CHAN, OUT_CHAN;
    logic [7:0] exp_q[$], chinv[4];
    logic [2:0] chsub[4], ph[4], gsub;
    logic tsel[4], en;
    int n_errors, num_checks, rep;
    rx_payload_control dut (.*);
    backplane_sink sink (.*);
    // 5 ns clock
    always #2.5 CLK = ~CLK;
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // Substitution, inversion, then replacement
    function automatic logic [7:0] expf(logic [7:0] x, g, int c);
        logic [2:0] k;
        logic [7:0] e;
        k = (gsub != 3'h0) ? gsub : chsub[c];
        e = (k == rx_payload_pkg::SUB_TRUNK) ? 8'h5a ^ 8'(c) : x;
        if (k inside {[3'h2:3'h4]}) begin
            e = (k == 3'h3) ? rx_payload_pkg::MW_ALAW[ph[c]] :
                rx_payload_pkg::MW_ULAW[ph[c]];
            ph[c] = ph[c] + 3'h1;
        end
        e = e ^ chinv[c];
        if (rep == 2 || (rep == 1 && tsel[c])) e = g;
        return en ? e : x;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo(int n);
        if (n >= 64) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        int n;
        AWADDR <= a;
        WDATA <= {24'h0, v};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1) break;
        end
        BREADY <= 1'b0;
        tmo(n);
        @(posedge CLK);
    endtask
    task automatic rd(logic [7:0] a);
        int n;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) break;
        end
        d = RDATA[7:0];
        r = RRESP;
        RREADY <= 1'b0;
        tmo(n);
        @(posedge CLK);
    endtask
    // Table write, then busy must be clear
    task automatic icw(logic [6:0] a, logic [7:0] v);
        wr(rx_payload_pkg::OFF_ACC_DATA, v);
        wr(rx_payload_pkg::OFF_ACC_CTRL, {1'b0, a});
        rd(rx_payload_pkg::OFF_ACC_STAT);
        chk(d & 8'h01, 8'h00);
    endtask
    task automatic burst(string t);
        int i, n, c;
        logic [7:0] x, g;
        for (i = 0; i < 24; i++) begin
            x = 8'(rnd());
            g = 8'(rnd());
            c = int'(rnd() % 4);
            IN_DATA <= x;
            PRBS_GEN_DATA <= g;
            IN_CHAN <= 5'(c);
            IN_SIG <= 4'(rnd());
            IN_VALID <= 1'b1;
            exp_q.push_back(expf(x, g, c));
            for (n = 0; n < 64; n++) begin
                @(posedge CLK);
                if (IN_READY === 1'b1) break;
            end
            tmo(n);
        end
        IN_VALID <= 1'b0;
        for (n = 0; n < 64 && exp_q.size() != 0; n++) @(posedge CLK);
        tmo(n);
        $display("test %s done", t);
    endtask
    // Output words against queued expectations
    always @(posedge CLK) begin
        if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
            chk(RX_SERIAL_DATA_OUT, exp_q.pop_front());
        end
    end
    // Main sequence
    initial begin
        {CLK, AWVALID, WVALID, BREADY, ARVALID, RREADY, IN_VALID} = '0;
        {AWADDR, ARADDR, WDATA, IN_DATA, PRBS_GEN_DATA, IN_SIG} = '0;
        {IN_CHAN, IN_SIG_FRAME, en, gsub, rep} = '0;
        WSTRB = 4'h1;
        SYS_RST = 1'b1;
        s = 32'd33208;
        chinv = '{default: 8'h00};
        chsub = '{default: 3'h0};
        ph = chsub;
        tsel = '{1'b1, 1'b0, 1'b0, 1'b0};
        repeat (6) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        rd(rx_payload_pkg::OFF_CTRL);
        chk(d, 8'h00);
        rd(8'h40);
        chk(8'(r), 8'(rx_payload_pkg::RESP_DECERR));
        wr(rx_payload_pkg::OFF_CFG, 8'h01);
        gsub = rx_payload_pkg::SUB_TRUNK;
        burst("disabled");
        for (int c = 0; c < 4; c++) icw(7'h20 + 7'(c), 8'h5a ^ 8'(c));
        wr(rx_payload_pkg::OFF_CTRL, 8'h01);
        en = 1'b1;
        burst("global trunk");
        wr(rx_payload_pkg::OFF_ACC_CTRL, 8'ha2);
        rd(rx_payload_pkg::OFF_ACC_DATA);
        chk(d, 8'h58);
        icw(7'h00, 8'h48);
        icw(7'h01, 8'h03);
        icw(7'h02, 8'h02);
        icw(7'h03, 8'h30);
        chsub = '{3'h0, 3'h3, 3'h2, 3'h0};
        chinv = '{8'haa, 8'h00, 8'h00, 8'hd5};
        wr(rx_payload_pkg::OFF_CFG, 8'h00);
        gsub = 3'h0;
        burst("per channel");
        wr(rx_payload_pkg::OFF_TEST, 8'h07);
        rep = 1;
        burst("framed replace");
        wr(rx_payload_pkg::OFF_TEST, 8'h03);
        rep = 2;
        burst("unframed replace");
        wr(rx_payload_pkg::OFF_TEST, 8'h01);
        rep = 0;
        burst("extract");
        complete_run();
    end
endmodule
bind rx_payload_control rx_payload_checks checks (.*);
`default_nettype wire
